// ==== hw/pfsac_defs.vh ====
`ifndef PFSAC_DEFS_VH
`define PFSAC_DEFS_VH

// Register byte addresses
`define PFSAC_OFS_DATA_LOW   5'h00
`define PFSAC_OFS_DATA_HIGH  5'h04
`define PFSAC_OFS_ADDR_LOW   5'h08
`define PFSAC_OFS_ADDR_HIGH  5'h0C
`define PFSAC_OFS_CONTROL    5'h10
`define PFSAC_OFS_UNLOCK     5'h14
`define PFSAC_OFS_IRQ_STAT   5'h18
`define PFSAC_OFS_IRQ_MASK   5'h1C

// Control register bit positions
`define PFSAC_CTL_CONFIG_SPACE_SELECT   6
`define PFSAC_CTL_LATCH_LOAD_ONLY   5
`define PFSAC_CTL_ERASE  4
`define PFSAC_CTL_ERR    3
`define PFSAC_CTL_EN     2
`define PFSAC_CTL_WR     1
`define PFSAC_CTL_RD     0

// Interrupt status bit positions
`define PFSAC_IRQ_DONE   0
`define PFSAC_IRQ_ERR    1

// Unlock pattern
`define PFSAC_KEY_FIRST  8'h55
`define PFSAC_KEY_SECOND 8'hAA

// Configuration space word addresses
`define PFSAC_CFG_UID_LAST  15'h0003
`define PFSAC_CFG_DEVID     15'h0006
`define PFSAC_CFG_WORD1     15'h0007
`define PFSAC_CFG_WORD2     15'h0008

// Values
`define PFSAC_BLANK_WORD    14'h3FFF
`define PFSAC_ADDR_HI_PAD   1'b1
`define PFSAC_CTL_PAD       1'b1
`define PFSAC_LAST_LATCH    5'h1F

// Self-timed program/erase time
`define PFSAC_CLK_NS        20
`define PFSAC_TPROG_NS      2000
`define PFSAC_TPROG_CYC     ((`PFSAC_TPROG_NS + `PFSAC_CLK_NS - 1) / `PFSAC_CLK_NS)

`endif

// ==== hw/pfsac_ctrl.v ====
// Function
// - Space select 1 targets user-ID/identity/config words, 0 targets program flash.
// - Config-space read at an unlisted address clears both data registers.
// - Config map: 0-3 user IDs rw, 6 identity ro, 7-8 config words ro.
// - Data low holds bits 7:0, data high bits 13:8, top two read zero.
// - Address low bits 7:0, address high bits 14:8, its bit 7 reads one.
// - Latch-only set: write command just loads the addressed latch.
// - Latch-only clear: load addressed latch then program all latches to flash.
// - Latch-only ignored while erase select is set.
// - Erase select erases addressed row, cleared by hardware on completion.
// - Error flag set on any start-write attempt but a latch-only load, cleared on normal completion.
// - Enable bit 0 inhibits all program and erase cycles.
// - Start-write launches self-timed operation, hardware clears it; software only sets.
// - Start-read loads data registers in one cycle then self-clears; zero writes ignored.
// - Control bit 7 reads one; bits 6..0 are the listed control bits.
// - Unlock register is write-only, eight bits, reset to zero.
// - All row latches return to 3FFFh after each completed write or erase.
// - Low five address bits pick the latch, upper ten the row.
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "pfsac_defs.vh"

module pfsac_ctrl #(
  parameter        ADDR_W     = 15,
  parameter        LATCH_W    = 5,
  parameter        TPROG_CYC  = `PFSAC_TPROG_CYC,
  parameter [13:0] DEVICE_ID  = 14'h0123,  // Arbitrary identity value
  parameter [13:0] CONFIG_W1  = 14'h3FFF,
  parameter [13:0] CONFIG_W2  = 14'h3FFF
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         irq
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WALK = 2'd1;
  localparam ST_TIME = 2'd2;
  localparam ST_DONE = 2'd3;

  localparam UL_IDLE  = 2'd0;
  localparam UL_FIRST = 2'd1;
  localparam UL_ARMED = 2'd2;

  localparam NLATCH = 1 << LATCH_W;

  reg [13:0] flash_mem [0:(1 << ADDR_W)-1];
  reg [13:0] latch_ff  [0:NLATCH-1];
  reg [13:0] uid_ff    [0:3];

  reg [13:0] word_ff;
  reg [14:0] addr_ff;
  reg        config_space_select_ff;
  reg        latch_load_only_ff;
  reg        erase_ff;
  reg        err_ff;
  reg        en_ff;
  reg        wr_ff;
  reg        rd_ff;
  reg [1:0]  unlock_ff;
  reg [1:0]  state_ff;
  reg [LATCH_W-1:0] idx_ff;
  reg [15:0] timer_ff;
  reg [1:0]  irq_stat_ff;
  reg [1:0]  irq_mask_ff;
  reg        irq_done_ff;
  reg        irq_err_ff;

  wire req    = avs_read | avs_write;
  wire commit = req & ~avs_waitrequest;
  wire wr_cmt = commit & avs_write;
  wire rd_cmt = commit & avs_read;
  wire [7:0] wbyte = avs_writedata[7:0];

  wire ctl_wr   = wr_cmt & (avs_address == `PFSAC_OFS_CONTROL);
  wire start_hit = ctl_wr & wbyte[`PFSAC_CTL_WR] & ~wr_ff;
  wire go = start_hit & (unlock_ff == UL_ARMED) & en_ff & (state_ff == ST_IDLE);

  wire [LATCH_W-1:0] latch_sel = addr_ff[LATCH_W-1:0];
  wire [ADDR_W-LATCH_W-1:0] row_sel = addr_ff[ADDR_W-1:LATCH_W];

  // Config-space word lookup, zero outside the readable set
  function [13:0] cfg_word;
    input [14:0] a;
    input [13:0] u0;
    input [13:0] u1;
    input [13:0] u2;
    input [13:0] u3;
    begin
      if (a <= `PFSAC_CFG_UID_LAST) begin
        case (a[1:0])
          2'd0:    cfg_word = u0;
          2'd1:    cfg_word = u1;
          2'd2:    cfg_word = u2;
          default: cfg_word = u3;
        endcase
      end else if (a == `PFSAC_CFG_DEVID) begin
        cfg_word = DEVICE_ID;
      end else if (a == `PFSAC_CFG_WORD1) begin
        cfg_word = CONFIG_W1;
      end else if (a == `PFSAC_CFG_WORD2) begin
        cfg_word = CONFIG_W2;
      end else begin
        cfg_word = 14'h0000;
      end
    end
  endfunction

  // Register read mux
  function [7:0] reg_read;
    input [4:0] a;
    begin
      case (a)
        `PFSAC_OFS_DATA_LOW:  reg_read = word_ff[7:0];
        `PFSAC_OFS_DATA_HIGH: reg_read = {2'b00, word_ff[13:8]};
        `PFSAC_OFS_ADDR_LOW:  reg_read = addr_ff[7:0];
        `PFSAC_OFS_ADDR_HIGH: reg_read = {`PFSAC_ADDR_HI_PAD, addr_ff[14:8]};
        `PFSAC_OFS_CONTROL:   reg_read = {`PFSAC_CTL_PAD, config_space_select_ff, latch_load_only_ff, erase_ff,
                                          err_ff, en_ff, wr_ff, rd_ff};
        `PFSAC_OFS_IRQ_STAT:  reg_read = {6'h00, irq_stat_ff};
        `PFSAC_OFS_IRQ_MASK:  reg_read = {6'h00, irq_mask_ff};
        default:              reg_read = 8'h00;
      endcase
    end
  endfunction

  // Flash array port: row walk for program and erase
  reg               mem_we;
  reg [ADDR_W-1:0]  mem_wa;
  reg [13:0]        mem_wd;
  always @* begin
    mem_we = ce & ~rst & (state_ff == ST_WALK) & ~config_space_select_ff;
    mem_wa = {row_sel, idx_ff};
    mem_wd = erase_ff ? `PFSAC_BLANK_WORD : latch_ff[idx_ff];
  end

  always @(posedge clk) begin
    if (mem_we) begin
      flash_mem[mem_wa] <= mem_wd;
    end
  end

  // Bus handshake: one wait cycle, access commits when waitrequest is low
  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if (req & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h00_0000, reg_read(avs_address)};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Unlock sequence tracker
  always @(posedge clk) begin
    if (rst) begin
      unlock_ff <= UL_IDLE;
    end else if (ce & wr_cmt) begin
      if (avs_address == `PFSAC_OFS_UNLOCK) begin
        if (wbyte == `PFSAC_KEY_FIRST) begin
          unlock_ff <= UL_FIRST;
        end else if ((wbyte == `PFSAC_KEY_SECOND) && (unlock_ff == UL_FIRST)) begin
          unlock_ff <= UL_ARMED;
        end else begin
          unlock_ff <= UL_IDLE;
        end
      end else begin
        unlock_ff <= UL_IDLE;
      end
    end
  end

  // Latch-only start versus a real program or erase run
  wire load_only = go & ~config_space_select_ff & latch_load_only_ff & ~erase_ff;
  wire run_go    = go & ~load_only;

  // Data and address register pairs
  always @(posedge clk) begin
    if (rst) begin
      word_ff <= 14'h0000;
      addr_ff <= 15'h0000;
    end else if (ce) begin
      if (wr_cmt) begin
        case (avs_address)
          `PFSAC_OFS_DATA_LOW:  word_ff[7:0]  <= wbyte;
          `PFSAC_OFS_DATA_HIGH: word_ff[13:8] <= wbyte[5:0];
          `PFSAC_OFS_ADDR_LOW:  addr_ff[7:0]  <= wbyte;
          `PFSAC_OFS_ADDR_HIGH: addr_ff[14:8] <= wbyte[6:0];
          default: ;
        endcase
      end
      // Read completes in one cycle and wins over a bus write
      if (rd_ff) begin
        if (config_space_select_ff) begin
          word_ff <= cfg_word(addr_ff, uid_ff[0], uid_ff[1], uid_ff[2], uid_ff[3]);
        end else begin
          word_ff <= flash_mem[addr_ff[ADDR_W-1:0]];
        end
      end
    end
  end

  // Control bits; writes while busy change nothing but flag an error when start-write is set
  always @(posedge clk) begin
    if (rst) begin
      config_space_select_ff  <= 1'b0;
      latch_load_only_ff  <= 1'b0;
      erase_ff <= 1'b0;
      err_ff   <= 1'b0;
      en_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
    end else if (ce) begin
      if (ctl_wr && (state_ff == ST_IDLE)) begin
        config_space_select_ff  <= wbyte[`PFSAC_CTL_CONFIG_SPACE_SELECT];
        latch_load_only_ff  <= wbyte[`PFSAC_CTL_LATCH_LOAD_ONLY];
        erase_ff <= wbyte[`PFSAC_CTL_ERASE];
        en_ff    <= wbyte[`PFSAC_CTL_EN];
        err_ff   <= wbyte[`PFSAC_CTL_ERR] | wbyte[`PFSAC_CTL_WR];
        if (wbyte[`PFSAC_CTL_RD]) begin
          rd_ff <= 1'b1;
        end
      end else if (ctl_wr && wbyte[`PFSAC_CTL_WR]) begin
        err_ff <= 1'b1;
      end
      if (rd_ff) begin
        rd_ff <= 1'b0;
      end
      if (load_only) begin
        err_ff <= 1'b0;
      end
      if (run_go) begin
        wr_ff <= 1'b1;
      end
      if (state_ff == ST_DONE) begin
        wr_ff    <= 1'b0;
        erase_ff <= 1'b0;
        err_ff   <= 1'b0;
      end
    end
  end

  // Row write latches and user-ID words
  integer i;
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < NLATCH; i = i + 1) begin
        latch_ff[i] <= `PFSAC_BLANK_WORD;
      end
      for (i = 0; i < 4; i = i + 1) begin
        uid_ff[i] <= `PFSAC_BLANK_WORD;
      end
    end else if (ce) begin
      if (go && config_space_select_ff && !erase_ff && (addr_ff <= `PFSAC_CFG_UID_LAST)) begin
        uid_ff[addr_ff[1:0]] <= word_ff;
      end
      if (go && !config_space_select_ff && !erase_ff) begin
        latch_ff[latch_sel] <= word_ff;
      end
      if (state_ff == ST_DONE) begin
        for (i = 0; i < NLATCH; i = i + 1) begin
          latch_ff[i] <= `PFSAC_BLANK_WORD;
        end
      end
    end
  end

  // Sequencer next state: config writes skip the row walk
  reg [1:0]         nxt_state;
  reg [LATCH_W-1:0] nxt_idx;
  reg [15:0]        nxt_timer;
  always @* begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_timer = timer_ff;
    case (state_ff)
      ST_IDLE: begin
        if (run_go && config_space_select_ff) begin
          nxt_timer = 16'h0000;
          nxt_state = ST_TIME;
        end else if (run_go) begin
          nxt_idx   = {LATCH_W{1'b0}};
          nxt_state = ST_WALK;
        end
      end
      ST_WALK: begin
        nxt_idx = idx_ff + 1'b1;
        if (idx_ff == `PFSAC_LAST_LATCH) begin
          nxt_timer = 16'h0000;
          nxt_state = ST_TIME;
        end
      end
      ST_TIME: begin
        nxt_timer = timer_ff + 1'b1;
        if (timer_ff >= TPROG_CYC - 1) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and one-cycle event pulses
  always @(posedge clk) begin
    if (rst) begin
      state_ff    <= ST_IDLE;
      idx_ff      <= {LATCH_W{1'b0}};
      timer_ff    <= 16'h0000;
      irq_done_ff <= 1'b0;
      irq_err_ff  <= 1'b0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      idx_ff      <= nxt_idx;
      timer_ff    <= nxt_timer;
      irq_done_ff <= (state_ff == ST_DONE);
      irq_err_ff  <= start_hit & ~go;
    end
  end

  // Interrupt status: set wins over read-clear
  wire      stat_rd = rd_cmt & (avs_address == `PFSAC_OFS_IRQ_STAT);
  reg [1:0] nxt_irq_stat;
  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (stat_rd) begin
      nxt_irq_stat = 2'b00;
    end
    if (irq_done_ff) begin
      nxt_irq_stat[`PFSAC_IRQ_DONE] = 1'b1;
    end
    if (irq_err_ff) begin
      nxt_irq_stat[`PFSAC_IRQ_ERR] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      irq_stat_ff <= 2'b00;
      irq_mask_ff <= 2'b00;
      irq         <= 1'b0;
    end else if (ce) begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_cmt && (avs_address == `PFSAC_OFS_IRQ_MASK)) begin
        irq_mask_ff <= wbyte[1:0];
      end
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

endmodule
`default_nettype wire

// ==== sim/pfsac_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfsac_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rtake = avs_read && avs_waitrequest;
  wire rdone = avs_read && !avs_waitrequest;
  a_ctl_pad: assert property (rtake && avs_address == 5'h10 |=> avs_readdata[7])
    else $error("control bit 7 not one");
  a_addrh_pad: assert property (rtake && avs_address == 5'h0C |=> avs_readdata[7])
    else $error("address high bit 7 not one");
  a_datah_top: assert property (rtake && avs_address == 5'h04 |=> avs_readdata[7:6] == 2'b00)
    else $error("data high top bits not zero");
  a_unlock_zero: assert property (rtake && avs_address == 5'h14 |=> avs_readdata == 0)
    else $error("unlock register readable");
  a_busy_err: assert property (rdone && avs_address == 5'h10 && avs_readdata[1] |-> avs_readdata[3])
    else $error("running operation without error flag");
  a_ack_prompt: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in one cycle");
  a_ack_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest [*1])
    else $error("answer held too long");
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
endmodule
bind pfsac_ctrl pfsac_props i_pfsac_props (
  .clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq)
);
`default_nettype wire

// ==== sim/pfsac_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfsac_ctrl_bench;
  logic        clk = 0;
  logic        rst = 1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         irq;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] q;
  always #10 clk = ~clk;
  // Identity and config word values are arbitrary
  pfsac_ctrl #(.TPROG_CYC(2), .DEVICE_ID(14'h2A5C), .CONFIG_W1(14'h1555)) i_pfsac_ctrl (
    .clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  task report_and_stop;
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input [4:0] a, input w, input [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task rc(input string nm, input [4:0] a, input [31:0] e);
    bus(a, 0, 8'h00);
    chk(nm, q, e);
  endtask
  task setw(input [14:0] a, input [13:0] d);
    bus(5'h08, 1, a[7:0]);
    bus(5'h0C, 1, {1'b0, a[14:8]});
    bus(5'h00, 1, d[7:0]);
    bus(5'h04, 1, {2'b00, d[13:8]});
  endtask
  task fetch(input [14:0] a, input [7:0] c, input [13:0] e);
    setw(a, 14'h0000);
    bus(5'h10, 1, c | 8'h01);
    rc("word low", 5'h00, {24'h00_0000, e[7:0]});
    rc("word high", 5'h04, {26'h000_0000, e[13:8]});
  endtask
  task start(input [7:0] c);
    bus(5'h14, 1, 8'h55);
    bus(5'h14, 1, 8'hAA);
    bus(5'h10, 1, c);
  endtask
  task wait_wr;
    do begin
      bus(5'h10, 0, 8'h00);
    end while (q[1] !== 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc("ctl reset", 5'h10, 32'h0000_0080);
    rc("addr high reset", 5'h0C, 32'h0000_0080);
    rc("unlock reset", 5'h14, 32'h0000_0000);
    bus(5'h0C, 1, 8'hFF);
    rc("addr high", 5'h0C, 32'h0000_00FF);
    bus(5'h04, 1, 8'hFF);
    rc("data high", 5'h04, 32'h0000_003F);
    bus(5'h14, 1, 8'h55);
    rc("unlock read", 5'h14, 32'h0000_0000);
    rc("unmapped", 5'h03, 32'h0000_0000);
    fetch(15'h0006, 8'h40, 14'h2A5C);
    rc("read bit clear", 5'h10, 32'h0000_00C0);
    fetch(15'h0005, 8'h40, 14'h0000);
    bus(5'h10, 1, 8'h44);
    setw(15'h0001, 14'h1234);
    start(8'h46);
    wait_wr;
    rc("cfg done", 5'h10, 32'h0000_00C4);
    fetch(15'h0001, 8'h44, 14'h1234);
    setw(15'h0007, 14'h0000);
    start(8'h46);
    wait_wr;
    fetch(15'h0007, 8'h44, 14'h1555);
    bus(5'h18, 0, 8'h00);
    bus(5'h10, 1, 8'h00);
    start(8'h02);
    rc("no enable", 5'h10, 32'h0000_0088);
    bus(5'h10, 1, 8'h04);
    bus(5'h10, 1, 8'h06);
    rc("no key", 5'h10, 32'h0000_008C);
    bus(5'h1C, 1, 8'h02);
    @(posedge clk);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    rc("status", 5'h18, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("irq off", {31'h0, irq}, 32'h0000_0000);
    bus(5'h10, 1, 8'h24);
    setw(15'h0043, 14'h2BCD);
    start(8'h26);
    rc("latch only", 5'h10, 32'h0000_00A4);
    bus(5'h10, 1, 8'h04);
    setw(15'h0045, 14'h1111);
    start(8'h06);
    wait_wr;
    fetch(15'h0043, 8'h04, 14'h2BCD);
    fetch(15'h0045, 8'h04, 14'h1111);
    bus(5'h10, 1, 8'h24);
    setw(15'h0047, 14'h0777);
    start(8'h26);
    bus(5'h10, 1, 8'h34);
    setw(15'h0040, 14'h0000);
    start(8'h36);
    wait_wr;
    rc("erase done", 5'h10, 32'h0000_00A4);
    fetch(15'h0045, 8'h04, 14'h3FFF);
    bus(5'h10, 1, 8'h04);
    setw(15'h0041, 14'h0AAA);
    start(8'h06);
    wait_wr;
    fetch(15'h0047, 8'h04, 14'h3FFF);
    fetch(15'h0041, 8'h04, 14'h0AAA);
    report_and_stop;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
endmodule
`default_nettype wire
